// file: rtl/cfgseq_pkg.sv
// package of constants and types for the configuration mode sequencer
package cfgseq_pkg;
  // system clock, configuration port rate and worst case load time
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned XFER_MHZ = 100;
  localparam int unsigned LOAD_MAX_MS = 100;
  // cycles of clk_sys per byte accepted at the parallel rate
  localparam int unsigned BYTE_CYC = (CLK_MHZ + XFER_MHZ - 1) / XFER_MHZ;
  // default configuration image length in bytes
  localparam int unsigned IMG_BYTES = 1024;
  // cycles the reset pulse of initialization lasts
  localparam int unsigned INIT_CYC = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // transfer formats that the host may choose
  typedef enum logic [1:0] {
    CFGSEQ_SER_SYNC,
    CFGSEQ_SER_ASYNC,
    CFGSEQ_PAR_SYNC,
    CFGSEQ_PAR_ASYNC
  } cfgseq_fmt_t;
  typedef enum logic [1:0] {
    CFGSEQ_ST_IDLE,
    CFGSEQ_ST_LOAD,
    CFGSEQ_ST_INIT,
    CFGSEQ_ST_USER
  } cfgseq_state_t;
endpackage

// file: rtl/cfgseq_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module cfgseq_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [WIDTH-1:0] data_ff;
  logic valid_ff;
  // count is one bit wider than the pointers so that depth itself fits
  wire full = (count_ff == (AW+1)'(DEPTH));
  wire empty = (count_ff == '0);
  wire push = in_valid_in && !full;
  // output register refills when empty or consumed
  wire load = !empty && (!valid_ff || out_ready_in);
  wire take = valid_ff && out_ready_in;

  function automatic logic [AW-1:0] incr(input logic [AW-1:0] p);
    incr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else if (flush_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= incr(wr_ptr_ff);
      end
      if (load) begin
        rd_ptr_ff <= incr(rd_ptr_ff);
        data_ff <= mem_ff[rd_ptr_ff];
        valid_ff <= 1'b1;
      end else if (take) begin
        valid_ff <= 1'b0;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  assign in_ready_out = !full;
  assign out_valid_out = valid_ff;
  assign out_data_out = data_ff;
endmodule // cfgseq_fifo

// file: rtl/cfgseq_top.sv
// configuration life cycle sequencer: load, initialize, user mode
`timescale 1ns/1ps
// Overview of operation
// [R01] power up unconfigured; full load needed
// [R02] after load, reset user logic, enable pins
// [R03] load plus init form command mode
// [R04] pins tri-stated until configuration ends
// [R05] weak pull-up on pins before user mode; code keeps it on in idle and load only, off during init
// [R06] trigger pin forces return to command mode
// [R07] reload, reinitialize, resume user mode
// [R08] serial or parallel, sync or async formats
// [R09] host writes words to one address
// [R10] byte path at 100 MHz, under 100 ms
// [R11] low pulse or test port starts reconfiguration
// [R12] trigger during load restarts the load
module cfgseq_top #(
  parameter int unsigned IMG_BYTES = cfgseq_pkg::IMG_BYTES,
  parameter int unsigned FIFO_DEPTH = cfgseq_pkg::FIFO_DEPTH
) (
  // clock and reset (reset stands for power-up)
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // reconfiguration requests
  input wire logic reconfig_trigger_n_in,
  input wire logic test_port_reconfig_pulse_in,
  // host write port: one virtual location
  input wire logic [1:0] host_fmt_in,
  input wire logic host_wr_in,
  input wire logic host_sclk_in,
  input wire logic [7:0] host_data_in,
  output logic host_ready_out,
  // device state
  output logic cmd_mode_out,
  output logic user_mode_out,
  output logic user_rst_out,
  output logic io_oe_out,
  output logic io_pullup_out,
  output logic cfg_done_out
);
  // pin synchronisers
  logic [1:0] trig_sync_ff;
  logic [1:0] wr_sync_ff;
  logic [1:0] sclk_sync_ff;
  logic [7:0] data_s1_ff;
  logic [7:0] data_s2_ff;
  logic trig_d_ff;
  logic wr_d_ff;
  logic sclk_d_ff;
  logic test_d_ff;
  cfgseq_pkg::cfgseq_state_t state_ff;
  cfgseq_pkg::cfgseq_state_t nxt_state;
  logic [31:0] byte_cnt_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] init_cnt_ff;
  logic [1:0] pace_ff;
  logic [7:0] cfg_mem_ff;
  logic host_ready_ff;
  logic cmd_mode_ff;
  logic user_mode_ff;
  logic user_rst_ff;
  logic io_oe_ff;
  logic io_pullup_ff;
  logic cfg_done_ff;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic nxt_host_ready;

  // edge and format decoding
  wire trig_fall = trig_d_ff && !trig_sync_ff[1];
  wire test_rise = test_port_reconfig_pulse_in && !test_d_ff;
  wire reconfig = trig_fall || test_rise; // [R11]
  wire is_par = host_fmt_in[1]; // [R08]
  wire is_sync = !host_fmt_in[0]; // [R08]
  // sync formats sample on the host clock rise, async on write strobe
  wire sclk_rise = sclk_sync_ff[1] && !sclk_d_ff;
  wire wr_rise = wr_sync_ff[1] && !wr_d_ff;
  wire strobe = is_sync ? (sclk_rise && wr_sync_ff[1]) : wr_rise; // [R08]
  wire loading = (state_ff == cfgseq_pkg::CFGSEQ_ST_LOAD);
  wire ser_full = (bit_cnt_ff == 3'h7);
  wire word_in = loading && strobe && (is_par || ser_full); // [R09]
  wire [7:0] word_val = is_par ? data_s2_ff :
                        {shift_ff[6:0], data_s2_ff[0]};
  // byte pacing keeps consumption at the parallel rate
  wire pace_ok = (pace_ff == 2'(cfgseq_pkg::BYTE_CYC - 1)); // [R10]
  wire consume = loading && fifo_out_valid && pace_ok;
  wire last_byte = consume && (byte_cnt_ff == 32'(IMG_BYTES - 1));
  wire init_end = (init_cnt_ff == 8'(cfgseq_pkg::INIT_CYC - 1));

  assign fifo_in_valid = word_in;
  assign fifo_in_data = word_val;

  cfgseq_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .flush_in(reconfig),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pace_ok && loading),
    .out_data_out(fifo_out_data)
  );

  // mode sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cfgseq_pkg::CFGSEQ_ST_IDLE: begin
        nxt_state = cfgseq_pkg::CFGSEQ_ST_LOAD; // [R01]
      end
      cfgseq_pkg::CFGSEQ_ST_LOAD: begin
        if (last_byte) begin
          nxt_state = cfgseq_pkg::CFGSEQ_ST_INIT; // [R02]
        end
      end
      cfgseq_pkg::CFGSEQ_ST_INIT: begin
        if (init_end) begin
          nxt_state = cfgseq_pkg::CFGSEQ_ST_USER; // [R02]
        end
      end
      default: begin
        nxt_state = cfgseq_pkg::CFGSEQ_ST_USER;
      end
    endcase
    if (reconfig) begin
      nxt_state = cfgseq_pkg::CFGSEQ_ST_IDLE; // [R06] [R12]
    end
  end

  assign nxt_host_ready = (nxt_state == cfgseq_pkg::CFGSEQ_ST_LOAD) &&
                          fifo_in_ready;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trig_sync_ff <= 2'h3;
      wr_sync_ff <= 2'h0;
      sclk_sync_ff <= 2'h0;
      data_s1_ff <= cfgseq_pkg::BYTE_RST;
      data_s2_ff <= cfgseq_pkg::BYTE_RST;
      trig_d_ff <= 1'b1;
      wr_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      test_d_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[0], reconfig_trigger_n_in};
      wr_sync_ff <= {wr_sync_ff[0], host_wr_in};
      sclk_sync_ff <= {sclk_sync_ff[0], host_sclk_in};
      data_s1_ff <= host_data_in;
      data_s2_ff <= data_s1_ff;
      trig_d_ff <= trig_sync_ff[1];
      wr_d_ff <= wr_sync_ff[1];
      sclk_d_ff <= sclk_sync_ff[1];
      test_d_ff <= test_port_reconfig_pulse_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= cfgseq_pkg::CFGSEQ_ST_IDLE;
      byte_cnt_ff <= '0;
      shift_ff <= cfgseq_pkg::BYTE_RST;
      bit_cnt_ff <= '0;
      init_cnt_ff <= '0;
      pace_ff <= '0;
      cfg_mem_ff <= cfgseq_pkg::BYTE_RST;
    end else begin
      state_ff <= nxt_state;
      if (!loading || reconfig) begin
        byte_cnt_ff <= '0; // [R07] [R12]
        bit_cnt_ff <= '0;
        pace_ff <= '0;
      end else begin
        if (consume) begin
          byte_cnt_ff <= byte_cnt_ff + 32'h1;
        end
        pace_ff <= pace_ok ? 2'h0 : pace_ff + 2'h1;
        if (strobe && !is_par && fifo_in_ready) begin
          shift_ff <= word_val;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
      end
      if (consume) begin
        cfg_mem_ff <= cfg_mem_ff ^ fifo_out_data;
      end
      init_cnt_ff <= (state_ff == cfgseq_pkg::CFGSEQ_ST_INIT) ?
                     init_cnt_ff + 8'h1 : 8'h0;
    end
  end

  // all outputs come from flops; pins stay high-z in command mode
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      host_ready_ff <= 1'b0;
      cmd_mode_ff <= 1'b1;
      user_mode_ff <= 1'b0;
      user_rst_ff <= 1'b1;
      io_oe_ff <= 1'b0;
      io_pullup_ff <= 1'b1;
      cfg_done_ff <= 1'b0;
    end else begin
      host_ready_ff <= nxt_host_ready;
      cmd_mode_ff <= (nxt_state != cfgseq_pkg::CFGSEQ_ST_USER); // [R03]
      user_mode_ff <= (nxt_state == cfgseq_pkg::CFGSEQ_ST_USER);
      user_rst_ff <= (nxt_state != cfgseq_pkg::CFGSEQ_ST_USER); // [R02]
      io_oe_ff <= (nxt_state == cfgseq_pkg::CFGSEQ_ST_USER); // [R04]
      io_pullup_ff <= (nxt_state == cfgseq_pkg::CFGSEQ_ST_IDLE) ||
                      (nxt_state == cfgseq_pkg::CFGSEQ_ST_LOAD); // [R05]
      cfg_done_ff <= (nxt_state == cfgseq_pkg::CFGSEQ_ST_INIT) ||
                     (nxt_state == cfgseq_pkg::CFGSEQ_ST_USER);
    end
  end

  assign host_ready_out = host_ready_ff;
  assign cmd_mode_out = cmd_mode_ff;
  assign user_mode_out = user_mode_ff;
  assign user_rst_out = user_rst_ff;
  assign io_oe_out = io_oe_ff;
  assign io_pullup_out = io_pullup_ff;
  assign cfg_done_out = cfg_done_ff;

  a_user_needs_load: assert property (@(posedge clk_sys_in) // [R01]
    disable iff (rst_in)
    $rose(user_mode_ff) |->
      $past(state_ff, 2) == cfgseq_pkg::CFGSEQ_ST_INIT)
    else $error("user mode entered without init");
  a_init_len: assert property (@(posedge clk_sys_in) // [R02]
    disable iff (rst_in)
    $rose(cfg_done_ff) && !reconfig |->
      ##16 user_mode_ff || $past(reconfig))
    else $error("init phase length wrong");
  a_cmd_user_excl: assert property (@(posedge clk_sys_in) // [R03]
    disable iff (rst_in)
    cmd_mode_out != user_mode_out)
    else $error("command and user mode overlap");
  a_pins_hiz_cmd: assert property (@(posedge clk_sys_in) // [R04]
    disable iff (rst_in)
    cmd_mode_out |-> !io_oe_out)
    else $error("pins driven in command mode");
  a_pullup_load: assert property (@(posedge clk_sys_in) // [R05]
    disable iff (rst_in)
    state_ff == cfgseq_pkg::CFGSEQ_ST_LOAD |-> io_pullup_out)
    else $error("pull-up off during load");
  a_trig_to_cmd: assert property (@(posedge clk_sys_in) // [R06]
    disable iff (rst_in)
    trig_fall |=> cmd_mode_out ##1 state_ff == cfgseq_pkg::CFGSEQ_ST_LOAD)
    else $error("trigger did not restart command mode");
  a_test_pulse: assert property (@(posedge clk_sys_in) // [R11]
    disable iff (rst_in)
    test_rise |=> state_ff == cfgseq_pkg::CFGSEQ_ST_IDLE)
    else $error("test port pulse ignored");
  a_abort_load: assert property (@(posedge clk_sys_in) // [R12]
    disable iff (rst_in)
    loading && reconfig |=> byte_cnt_ff == 32'h0 && !cfg_done_out)
    else $error("load not restarted");
  a_byte_pace: assert property (@(posedge clk_sys_in) // [R10]
    disable iff (rst_in)
    consume |=> !consume)
    else $error("bytes taken faster than 100 MHz");
endmodule // cfgseq_top

// file: bench/cfgseq_host.sv
// host model: writes configuration bytes and pulses the trigger pin
`timescale 1ns/1ps
module cfgseq_host (
  // clock and flow control
  input wire logic clk_sys_in,
  input wire logic host_ready_in,
  // host pins
  output logic [1:0] host_fmt_out,
  output logic host_wr_out,
  output logic host_sclk_out,
  output logic [7:0] host_data_out,
  output logic reconfig_trigger_n_out
);
  initial begin
    host_fmt_out = 2'h2;
    host_wr_out = 1'b0;
    host_sclk_out = 1'b0;
    host_data_out = 8'h00;
    reconfig_trigger_n_out = 1'b1;
  end
  // one strobe fits all formats: wr rises, then sclk rises while wr high
  task automatic strobe(input logic [7:0] d);
    host_data_out = d;
    host_wr_out = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    host_sclk_out = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    host_wr_out = 1'b0;
    host_sclk_out = 1'b0;
    // released data does not keep its last value
    host_data_out = ~d;
    repeat (4) @(negedge clk_sys_in);
  endtask
  // serial formats send bit0 msb first, parallel one byte per strobe
  task automatic send_byte(input logic [1:0] fmt, input logic [7:0] b);
    int i;
    int k;
    host_fmt_out = fmt;
    for (k = 0; k < 200 && host_ready_in !== 1'b1; k++) begin
      @(negedge clk_sys_in);
    end
    if (fmt[1]) begin
      strobe(b);
    end else begin
      for (i = 7; i >= 0; i--) begin
        strobe({7'h00, b[i]});
      end
    end
  endtask
  task automatic pulse_trigger();
    reconfig_trigger_n_out = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    reconfig_trigger_n_out = 1'b1;
  endtask
endmodule // cfgseq_host

// file: bench/cfgseq_top_tb_top.sv
// self-checking bench of the configuration mode sequencer
`timescale 1ns/1ps
`define CHK(a, b) comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end
module cfgseq_top_tb_top;
  localparam int unsigned IMG = 16;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic test_pulse = 1'b0;
  logic [1:0] fmt;
  logic wr, sclk, trig_n, ready, cmd, user, urst, oe, pull, done;
  logic [7:0] data;
  int error_cnt = 0;
  int comparisons = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  cfgseq_top #(.IMG_BYTES(IMG), .FIFO_DEPTH(8)) cfgseq_top_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reconfig_trigger_n_in(trig_n),
    .test_port_reconfig_pulse_in(test_pulse),
    .host_fmt_in(fmt), .host_wr_in(wr), .host_sclk_in(sclk),
    .host_data_in(data), .host_ready_out(ready),
    .cmd_mode_out(cmd), .user_mode_out(user), .user_rst_out(urst),
    .io_oe_out(oe), .io_pullup_out(pull), .cfg_done_out(done));
  cfgseq_host cfgseq_host_i (
    .clk_sys_in(clk_sys_in), .host_ready_in(ready),
    .host_fmt_out(fmt), .host_wr_out(wr), .host_sclk_out(sclk),
    .host_data_out(data), .reconfig_trigger_n_out(trig_n));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_hi(input bit sel_user);
    int k;
    for (k = 0; k < 200; k++) begin
      @(negedge clk_sys_in);
      if ((sel_user ? user : done) === 1'b1) break;
    end
  endtask
  // command mode state while unconfigured or loading
  task automatic chk_cmd();
    `CHK(cmd, 1'b1)
    `CHK(user, 1'b0)
    `CHK(oe, 1'b0)
    `CHK(pull, 1'b1)
    `CHK(urst, 1'b1)
    `CHK(done, 1'b0)
  endtask
  task automatic load_image(input logic [1:0] f, input int n);
    int i;
    for (i = 0; i < n - 1; i++) begin
      cfgseq_host_i.send_byte(f, 8'h5a ^ i[7:0]);
    end
    repeat (8) @(negedge clk_sys_in);
    chk_cmd();
    cfgseq_host_i.send_byte(f, 8'ha5);
    wait_hi(1'b0);
    `CHK(done, 1'b1)
    `CHK(pull, 1'b0)
    `CHK(oe, 1'b0)
    `CHK(cmd, 1'b1)
    `CHK(urst, 1'b1)
    wait_hi(1'b1);
    `CHK(user, 1'b1)
    `CHK(cmd, 1'b0)
    `CHK(oe, 1'b1)
    `CHK(urst, 1'b0)
    $display("test load format %0d done", f);
  endtask
  task automatic t_power_up();
    repeat (3) @(negedge clk_sys_in);
    chk_cmd();
    `CHK(ready, 1'b0)
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk_cmd();
    `CHK(ready, 1'b1)
    $display("test power_up done");
  endtask
  task automatic t_pin_reconfig();
    cfgseq_host_i.pulse_trigger();
    repeat (6) @(negedge clk_sys_in);
    chk_cmd();
    load_image(2'h0, IMG);
    $display("test pin_reconfig done");
  endtask
  task automatic t_test_port();
    test_pulse = 1'b1;
    @(negedge clk_sys_in);
    test_pulse = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk_cmd();
    load_image(2'h1, IMG);
    $display("test test_port done");
  endtask
  // a trigger mid-load must clear the byte count, not just pause it
  task automatic t_abort();
    int i;
    cfgseq_host_i.pulse_trigger();
    for (i = 0; i < 8; i++) begin
      cfgseq_host_i.send_byte(2'h3, i[7:0]);
    end
    cfgseq_host_i.pulse_trigger();
    repeat (6) @(negedge clk_sys_in);
    chk_cmd();
    load_image(2'h3, IMG);
    $display("test abort done");
  endtask
  initial begin
    t_power_up();
    load_image(2'h2, IMG);
    t_pin_reconfig();
    t_test_port();
    t_abort();
    complete_run();
  end
  initial begin
    #150000;
    error_cnt++;
    complete_run();
  end
endmodule // cfgseq_top_tb_top
